// ---- hw/measurement_feedback_status.sv ----
// Added by the designer: the address-and-strobe port and the address map.
`default_nettype none
module measurement_feedback_status (
  input  wire logic                      sys_clk_i,      // 10 MHz clock
  input  wire logic                      srst_i,         // Sync reset
  input  wire logic                      ce_i,           // Clock enable
  input  wire logic [mfs_pkg::ADDR_W-1:0] addr_i,        // Byte address
  input  wire logic [mfs_pkg::DATA_W-1:0] wdata_i,       // Write data
  input  wire logic                      wr_i,           // Write strobe
  input  wire logic                      rd_i,           // Read strobe
  input  wire logic                      di_pin_i,       // Digital input pin
  input  wire mfs_pkg::fault_pins_t      fault_pins_i,   // Fault sense pins
  input  wire mfs_pkg::meas_in_t         meas_i,         // Datapath status
  output logic [mfs_pkg::DATA_W-1:0]     rdata_o,        // Read data
  output mfs_pkg::feedback_t             feedback_o,     // Feedback bits
  output logic [mfs_pkg::NFLT-1:0]       faults_o,       // Latched faults
  output logic [mfs_pkg::NFLT-1:0]       diag_msg_o,     // Diag pulses
  output logic                           load_accept_o,  // Value accepted
  output logic [3:0]                     load_sel_o,     // Accepted target
  output logic                           value_update_o  // Update value
);
  import mfs_pkg::*;

  state_t          st_reg;
  state_t          st_next;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] filt_next;
  logic [NFLT-1:0] cause;
  logic [3:0]      ld_req;
  logic            ack;
  logic            rs_req;
  logic            iso;
  logic            cont;
  logic            rs_done;
  logic            ld_done;
  logic            mc_set;
  logic            gate_cause;

  function automatic logic multi_req(input logic [3:0] v);
    multi_req = (v & (v - 4'h1)) != 4'h0;
  endfunction : multi_req

  assign pin_raw = {di_pin_i, fault_pins_i};

  // Level change accepted once second and third stage agree
  generate
    for (genvar i = 0; i < NPIN; i++)
    begin : g_filt
      assign filt_next[i] = (st_reg.sync2[i] == st_reg.sync3[i])
                            ? st_reg.sync2[i] : st_reg.pin_lvl[i];
    end
  endgenerate

  assign cause[FLT_SUPPLY] = st_reg.pin_lvl[PIN_SUPPLY];
  assign cause[FLT_OUT1] = |st_reg.pin_lvl[PIN_OUT1 +: PIN_GRP];
  assign cause[FLT_OUT2] = |st_reg.pin_lvl[PIN_OUT2 +: PIN_GRP];
  assign cause[FLT_ENC] = |st_reg.pin_lvl[PIN_ENC +: PIN_GRP];

  assign ack    = st_reg.ctrl[CTL_ACK];
  assign rs_req = st_reg.ctrl[CTL_RSREQ];
  assign ld_req = st_reg.ctrl[CTL_LD_MSB:CTL_LD_LSB];
  assign iso    = st_reg.cfg[CFG_ISO];
  assign cont   = st_reg.cfg[CFG_CONT];

  // Isochrone handshakes take four bus ticks, otherwise one clock
  assign rs_done = (st_reg.rs_st == HS_RUN) &&
                   (!iso || (meas_i.bus_tick &&
                    st_reg.rs_cnt == ISO_TICKS - 3'h1));
  assign ld_done = (st_reg.ld_st == HS_RUN) &&
                   (!iso || (meas_i.bus_tick &&
                    st_reg.ld_cnt == ISO_TICKS - 3'h1));

  // Estimated values in continuous mode leave completion clear
  assign mc_set = meas_i.interval_done &&
                  (!cont || meas_i.true_value);
  assign gate_cause = meas_i.gate_open && meas_i.measuring;

  always_comb
  begin
    st_next        = st_reg;
    st_next.sync1  = pin_raw;
    st_next.sync2  = st_reg.sync1;
    st_next.sync3  = st_reg.sync2;
    st_next.pin_lvl = filt_next;
    st_next.rdata  = {DATA_W{1'b0}};
    st_next.ld_acc = 1'b0;

    if (wr_i)
    begin
      case (addr_i)
        ADDR_CTRL: st_next.ctrl = wdata_i[CTL_W-1:0];
        ADDR_CFG:  st_next.cfg  = wdata_i[CFG_W-1:0];
        default:   st_next.ctrl = st_next.ctrl;
      endcase
    end

    // Faults latch; a held acknowledge lets them follow the cause
    st_next.fault = cause | (st_reg.fault & ~{NFLT{ack}});
    st_next.diag  = st_next.fault & ~st_reg.fault &
                    st_reg.cfg[CFG_DIAG_MSB:CFG_DIAG_LSB];

    st_next.upd     = meas_i.interval_done;
    st_next.par_err = meas_i.param_invalid;

    case (st_reg.rs_st)
      HS_IDLE:
      begin
        if (rs_req)
        begin
          st_next.rs_st  = HS_RUN;
          st_next.rs_cnt = 3'h0;
        end
      end
      HS_RUN:
      begin
        if (meas_i.bus_tick)
        begin
          st_next.rs_cnt = st_reg.rs_cnt + 3'h1;
        end
        if (rs_done)
        begin
          st_next.rs_st = HS_HOLD;
        end
      end
      HS_HOLD:
      begin
        if (!rs_req)
        begin
          st_next.rs_st = HS_IDLE;
        end
      end
      default:
      begin
        st_next.rs_st = HS_IDLE;
      end
    endcase

    // New events win over the clear of the same cycle
    st_next.mc  = mc_set || (st_reg.mc && !rs_done);
    st_next.ovf = meas_i.high_violate ||
                  (st_reg.ovf && !rs_done);
    st_next.unf = meas_i.low_violate ||
                  (st_reg.unf && !rs_done);

    case (st_reg.ld_st)
      HS_IDLE:
      begin
        if (multi_req(ld_req))
        begin
          st_next.ld_err = 1'b1;
          st_next.ld_st  = HS_HOLD;
        end
        else if (ld_req != 4'h0)
        begin
          st_next.ld_st  = HS_RUN;
          st_next.ld_cnt = 3'h0;
        end
      end
      HS_RUN:
      begin
        if (multi_req(ld_req))
        begin
          st_next.ld_err = 1'b1;
          st_next.ld_st  = HS_HOLD;
        end
        else if (ld_req == 4'h0)
        begin
          st_next.ld_st = HS_IDLE;
        end
        else
        begin
          if (meas_i.bus_tick)
          begin
            st_next.ld_cnt = st_reg.ld_cnt + 3'h1;
          end
          if (ld_done)
          begin
            st_next.ld_st = HS_HOLD;
            if (meas_i.value_in_range)
            begin
              st_next.ld_acc = 1'b1;
              st_next.ld_sel = ld_req;
              st_next.ld_err = 1'b0;
            end
            else
            begin
              st_next.ld_err = 1'b1;
            end
          end
        end
      end
      HS_HOLD:
      begin
        if (ld_req == 4'h0)
        begin
          st_next.ld_st = HS_IDLE;
        end
      end
      default:
      begin
        st_next.ld_st = HS_IDLE;
      end
    endcase

    st_next.fb.measurement_complete = st_next.mc;
    st_next.fb.high_limit_violation = st_next.ovf;
    st_next.fb.low_limit_violation  = st_next.unf;
    st_next.fb.status_reset_active  =
      st_next.rs_st != HS_IDLE;
    st_next.fb.load_running = st_next.ld_st != HS_IDLE;
    st_next.fb.load_error   = st_next.ld_err;
    st_next.fb.param_assign_error = st_next.par_err;
    st_next.fb.gate_open_status   = gate_cause;
    st_next.fb.input_level_status = filt_next[PIN_DI];
    st_next.fb.output_one_status  = meas_i.out_one_level;
    st_next.fb.output_two_status  = meas_i.out_two_level;
    st_next.fb.count_up_status    = meas_i.count_up;
    st_next.fb.count_down_status  = meas_i.count_down;

    if (rd_i)
    begin
      case (addr_i)
        ADDR_CTRL:
          st_next.rdata = {{(DATA_W-CTL_W){1'b0}}, st_reg.ctrl};
        ADDR_CFG:
          st_next.rdata = {{(DATA_W-CFG_W){1'b0}}, st_reg.cfg};
        ADDR_FEEDBACK:
          st_next.rdata = {{(DATA_W-FB_W){1'b0}}, st_reg.fb};
        ADDR_FAULT:
          st_next.rdata = {{(DATA_W-NFLT){1'b0}}, st_reg.fault};
        default:
          st_next.rdata = {DATA_W{1'b0}};
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      st_reg <= ST_RST;
    end
    else if (ce_i)
    begin
      st_reg <= st_next;
    end
  end

  assign rdata_o        = st_reg.rdata;
  assign feedback_o     = st_reg.fb;
  assign faults_o       = st_reg.fault;
  assign diag_msg_o     = st_reg.diag;
  assign load_accept_o  = st_reg.ld_acc;
  assign load_sel_o     = st_reg.ld_sel;
  assign value_update_o = st_reg.upd;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  chk_fault_hold: assert property (
    (ce_i && !ack) |=>
      ((st_reg.fault & $past(st_reg.fault)) == $past(st_reg.fault)))
    else $error("Fault flag dropped without acknowledge");

  chk_supply_raise: assert property (
    (ce_i && st_reg.pin_lvl[PIN_SUPPLY]) |=> faults_o[FLT_SUPPLY])
    else $error("Supply short did not raise fault");

  chk_out_raise: assert property (
    (ce_i && |st_reg.pin_lvl[PIN_OUT2 +: PIN_GRP]) |=>
      faults_o[FLT_OUT2])
    else $error("Output two fault not raised");

  chk_enc_raise: assert property (
    (ce_i && |st_reg.pin_lvl[PIN_ENC +: PIN_GRP]) |=> faults_o[FLT_ENC])
    else $error("Encoder fault not raised");

  chk_diag_gate: assert property (
    (diag_msg_o & ~$past(st_reg.cfg[CFG_DIAG_MSB:CFG_DIAG_LSB]))
      == 4'h0)
    else $error("Diagnostic message without enable");

  chk_load_multi: assert property (
    (ce_i && st_reg.ld_st == HS_IDLE && multi_req(ld_req)) |=>
      (feedback_o.load_error && !load_accept_o))
    else $error("Multiple load requests not flagged");

  chk_load_range: assert property (
    (ce_i && ld_done && !multi_req(ld_req) && ld_req != 4'h0 &&
     !meas_i.value_in_range) |=> (feedback_o.load_error && !load_accept_o))
    else $error("Out-of-range load accepted");

  chk_mc_set: assert property (
    (ce_i && mc_set) |=> feedback_o.measurement_complete)
    else $error("Measurement complete not set");

  chk_mc_estimate: assert property (
    (ce_i && cont && meas_i.interval_done && !meas_i.true_value &&
     !st_reg.mc) |=> !feedback_o.measurement_complete)
    else $error("Estimated value marked complete");

  chk_limit_hold: assert property (
    (ce_i && st_reg.ovf && !rs_done) |=> feedback_o.high_limit_violation)
    else $error("Overflow flag lost without reset");

  chk_reset_drop: assert property (
    (ce_i && st_reg.rs_st == HS_HOLD && !rs_req) |=>
      (st_reg.rs_st == HS_IDLE && !feedback_o.status_reset_active))
    else $error("Reset-active not withdrawn");

  chk_gate_mirror: assert property (
    ce_i |=> (feedback_o.gate_open_status == $past(gate_cause)))
    else $error("Gate status does not follow gate");

  chk_iso_count: assert property (
    (ce_i && iso && st_reg.rs_st == HS_IDLE && rs_req) |=>
      (st_reg.rs_st == HS_RUN && st_reg.rs_cnt == 3'h0))
    else $error("Isochrone reset did not start counting");
endmodule : measurement_feedback_status
`default_nettype wire

// ---- inc/mfs_pkg.sv ----
`default_nettype none
package mfs_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_CFG      = 8'h04;
  localparam logic [7:0]  ADDR_FEEDBACK = 8'h08;
  localparam logic [7:0]  ADDR_FAULT    = 8'h0C;
  localparam int unsigned CTL_ACK       = 0;
  localparam int unsigned CTL_RSREQ     = 1;
  localparam int unsigned CTL_LD_LSB    = 2;
  localparam int unsigned CTL_LD_MSB    = 5;
  localparam int unsigned CTL_W         = 6;
  localparam int unsigned CFG_CONT      = 0;
  localparam int unsigned CFG_ISO       = 1;
  localparam int unsigned CFG_DIAG_LSB  = 2;
  localparam int unsigned CFG_DIAG_MSB  = 5;
  localparam int unsigned CFG_W         = 6;
  localparam int unsigned FLT_SUPPLY    = 0;
  localparam int unsigned FLT_OUT1      = 1;
  localparam int unsigned FLT_OUT2      = 2;
  localparam int unsigned FLT_ENC       = 3;
  localparam int unsigned NFLT          = 4;
  localparam int unsigned PIN_SUPPLY    = 0;
  localparam int unsigned PIN_OUT1      = 1;
  localparam int unsigned PIN_OUT2      = 4;
  localparam int unsigned PIN_ENC       = 7;
  localparam int unsigned PIN_GRP       = 3;
  localparam int unsigned PIN_DI        = 10;
  localparam int unsigned NPIN          = 11;
  localparam int unsigned FB_W          = 13;
  localparam logic [2:0]  ISO_TICKS     = 3'h4;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_RUN  = 2'b01,
    HS_HOLD = 2'b11
  } hs_state_t;

  typedef struct packed {
    logic enc_bad;
    logic enc_break;
    logic enc_short;
    logic out2_hot;
    logic out2_break;
    logic out2_short;
    logic out1_hot;
    logic out1_break;
    logic out1_short;
    logic supply_short;
  } fault_pins_t;

  typedef struct packed {
    logic interval_done;
    logic true_value;
    logic gate_open;
    logic measuring;
    logic high_violate;
    logic low_violate;
    logic count_up;
    logic count_down;
    logic out_one_level;
    logic out_two_level;
    logic value_in_range;
    logic param_invalid;
    logic bus_tick;
  } meas_in_t;

  typedef struct packed {
    logic count_down_status;
    logic count_up_status;
    logic output_two_status;
    logic output_one_status;
    logic input_level_status;
    logic gate_open_status;
    logic param_assign_error;
    logic load_error;
    logic load_running;
    logic status_reset_active;
    logic low_limit_violation;
    logic high_limit_violation;
    logic measurement_complete;
  } feedback_t;

  typedef struct packed {
    logic [NPIN-1:0]   sync1;
    logic [NPIN-1:0]   sync2;
    logic [NPIN-1:0]   sync3;
    logic [NPIN-1:0]   pin_lvl;
    logic [CTL_W-1:0]  ctrl;
    logic [CFG_W-1:0]  cfg;
    logic [NFLT-1:0]   fault;
    logic [NFLT-1:0]   diag;
    logic              mc;
    logic              ovf;
    logic              unf;
    logic              ld_err;
    logic              par_err;
    hs_state_t         rs_st;
    hs_state_t         ld_st;
    logic [2:0]        rs_cnt;
    logic [2:0]        ld_cnt;
    logic [3:0]        ld_sel;
    logic              ld_acc;
    logic              upd;
    feedback_t         fb;
    logic [DATA_W-1:0] rdata;
  } state_t;

  localparam state_t ST_RST = '0;
endpackage : mfs_pkg
`default_nettype wire

// ---- bench/mfs_master.sv ----
`default_nettype none
module mfs_master (
  input  wire logic                       sys_clk_i, // Bus clock
  input  wire logic [mfs_pkg::DATA_W-1:0] rdata_i,   // Read data
  output logic      [mfs_pkg::ADDR_W-1:0] addr_o,    // Address
  output logic      [mfs_pkg::DATA_W-1:0] wdata_o,   // Write data
  output logic                            wr_o,      // Write strobe
  output logic                            rd_o       // Read strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  import mfs_pkg::*;

  initial
  begin
    addr_o  = '0;
    wdata_o = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_o    <= 1'b1;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge sys_clk_i);
    wr_o    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    rd_o   <= 1'b1;
    addr_o <= a;
    @(posedge sys_clk_i);
    rd_o   <= 1'b0;
    @(posedge sys_clk_i);
    d = rdata_i;
  endtask : rd

  // Raise a request and poll, at most ten reads, until the device answers on feedback bit b
  task automatic req(input logic [31:0] r, input int b, output logic ok);
    logic [31:0] d;
    ok = 1'b0;
    wr(ADDR_CTRL, r);
    repeat (10)
    begin
      rd(ADDR_FEEDBACK, d);
      if (d[b] === 1'b1)
        ok = 1'b1;
      if (ok)
        break;
    end
  endtask : req
endmodule : mfs_master
`default_nettype wire

// ---- bench/measurement_feedback_status_tb_top.sv ----
`default_nettype none
module measurement_feedback_status_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mfs_pkg::*;

  logic              clk  = 1'b0;
  logic              srst = 1'b1;
  logic              ce   = 1'b1;
  logic              di   = 1'b0;
  fault_pins_t       pins = '0;
  meas_in_t          meas = '0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  feedback_t         fb;
  logic [NFLT-1:0]   flt;
  logic [NFLT-1:0]   diag;
  logic              acc;
  logic [3:0]        sel;
  logic              upd;
  logic [31:0]       seed = 32'h9E9CEF1F;
  logic [31:0]       d;
  logic              ok;
  int                fails = 0;
  int                total_checks = 0;
  int                diag_cnt[4] = '{default: 0};
  int                exp_diag[4] = '{default: 0};
  int                acc_cnt = 0;
  int                upd_cnt = 0;
  int                f;

  always #50 clk = ~clk;

  measurement_feedback_status measurement_feedback_status_i (
    .sys_clk_i(clk), .srst_i(srst), .ce_i(ce), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .di_pin_i(di),
    .fault_pins_i(pins), .meas_i(meas), .rdata_o(rdata),
    .feedback_o(fb), .faults_o(flt), .diag_msg_o(diag),
    .load_accept_o(acc), .load_sel_o(sel), .value_update_o(upd)
  );

  mfs_master mfs_master_i (
    .sys_clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd)
  );

  always @(posedge clk)
  begin
    for (int k = 0; k < 4; k++)
      if (diag[k] === 1'b1)
        diag_cnt[k]++;
    if (acc === 1'b1)
      acc_cnt++;
    if (upd === 1'b1)
      upd_cnt++;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic rfb(input int b, input logic e);
    mfs_master_i.rd(ADDR_FEEDBACK, d);
    chk(32'(d[b]), 32'(e));
  endtask : rfb

  task automatic ld(input logic [31:0] r, input logic err, input int n);
    mfs_master_i.req(r, 4, ok);
    chk(32'(ok), 32'h1);
    mfs_master_i.wr(ADDR_CTRL, 32'h0);
    rfb(5, err);
    chk(32'(d[4]), 32'h0);
    chk(32'(acc_cnt), 32'(n));
  endtask : ld

  task automatic pulse_meas(input logic tv, input logic viol);
    @(posedge clk);
    meas.interval_done <= 1'b1;
    meas.true_value    <= tv;
    meas.high_violate  <= viol;
    meas.low_violate   <= viol;
    @(posedge clk);
    meas.interval_done <= 1'b0;
    meas.high_violate  <= 1'b0;
    meas.low_violate   <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse_meas

  task automatic tick();
    @(posedge clk);
    meas.bus_tick <= 1'b1;
    @(posedge clk);
    meas.bus_tick <= 1'b0;
  endtask : tick

  initial
  begin
    #3000000;
    fails++;
    results();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    mfs_master_i.rd(ADDR_FEEDBACK, d);
    chk(d, 32'h0);
    mfs_master_i.rd(8'h10, d);
    chk(d, 32'h0);
    for (int p = 0; p < 10; p++)
    begin
      f = (p == 0) ? 0 : (p - 1) / 3 + 1;
      mfs_master_i.wr(ADDR_CFG, 32'(p % 2 == 0) << (2 + f));
      exp_diag[f] += (p % 2 == 0) ? 1 : 0;
      @(posedge clk);
      pins <= fault_pins_t'(10'h1 << p);
      repeat (8) @(posedge clk);
      pins <= '0;
      repeat (8) @(posedge clk);
      mfs_master_i.rd(ADDR_FAULT, d);
      chk(d, 32'h1 << f);
      chk(32'(diag_cnt[f]), 32'(exp_diag[f]));
      mfs_master_i.wr(ADDR_CTRL, 32'h1);
      mfs_master_i.wr(ADDR_CTRL, 32'h0);
      mfs_master_i.rd(ADDR_FAULT, d);
      chk(d, 32'h0);
    end
    mfs_master_i.wr(ADDR_CTRL, 32'h1);
    pins <= 10'h1;
    repeat (8) @(posedge clk);
    mfs_master_i.rd(ADDR_FAULT, d);
    chk(d, 32'h1);
    pins <= '0;
    repeat (8) @(posedge clk);
    mfs_master_i.rd(ADDR_FAULT, d);
    chk(d, 32'h0);
    mfs_master_i.wr(ADDR_CTRL, 32'h0);
    mfs_master_i.wr(ADDR_CFG, 32'h0);
    pulse_meas(1'b0, 1'b1);
    chk(32'(upd_cnt), 32'h1);
    mfs_master_i.rd(ADDR_FEEDBACK, d);
    chk(32'(d[2:0]), 32'h7);
    repeat (20) @(posedge clk);
    rfb(1, 1'b1);
    mfs_master_i.req(32'h2, 3, ok);
    chk(32'(ok), 32'h1);
    mfs_master_i.rd(ADDR_FEEDBACK, d);
    chk(32'(d[2:0]), 32'h0);
    mfs_master_i.wr(ADDR_CTRL, 32'h0);
    rfb(3, 1'b0);
    mfs_master_i.wr(ADDR_CFG, 32'h1);
    pulse_meas(1'b0, 1'b0);
    rfb(0, 1'b0);
    pulse_meas(1'b1, 1'b0);
    rfb(0, 1'b1);
    mfs_master_i.wr(ADDR_CFG, 32'h2);
    mfs_master_i.req(32'h2, 3, ok);
    chk(32'(ok), 32'h1);
    repeat (3) tick();
    rfb(0, 1'b1);
    tick();
    repeat (2) @(posedge clk);
    rfb(0, 1'b0);
    mfs_master_i.wr(ADDR_CTRL, 32'h0);
    mfs_master_i.wr(ADDR_CFG, 32'h0);
    meas.value_in_range <= 1'b1;
    ld(32'hC, 1'b1, 0);
    for (int b = 0; b < 4; b++)
    begin
      ld(32'h4 << b, 1'b0, b + 1);
      chk(32'(sel), 32'h1 << b);
    end
    meas.value_in_range <= 1'b0;
    ld(32'h4, 1'b1, 4);
    chk(32'(sel), 32'h8);
    // Frozen clock enable: an interval and a violation leave no trace
    ce <= 1'b0;
    pulse_meas(1'b1, 1'b1);
    ce <= 1'b1;
    chk(32'(upd_cnt), 32'h3);
    rfb(1, 1'b0);
    for (int i = 0; i < 20; i++)
    begin
      seed = xs(seed);
      mfs_master_i.wr(ADDR_CFG, {26'h0, seed[13:8]});
      mfs_master_i.rd(ADDR_CFG, d);
      chk(d, {26'h0, seed[13:8]});
      di <= seed[0];
      meas.gate_open     <= seed[1];
      meas.measuring     <= seed[2];
      meas.count_up      <= seed[3];
      meas.count_down    <= seed[4];
      meas.out_one_level <= seed[5];
      meas.out_two_level <= seed[6];
      meas.param_invalid <= seed[7];
      repeat (6) @(posedge clk);
      mfs_master_i.rd(ADDR_FEEDBACK, d);
      chk(32'(d[12:6]), 32'({seed[4:3], seed[6:5], seed[0],
          seed[1] & seed[2], seed[7]}));
    end
    results();
  end
endmodule : measurement_feedback_status_tb_top
`default_nettype wire
